// ---- logic/gpp_map.svh ----
// Purpose: register map, field masks and reset values of the port block
// Assumes: word-addressed register bus, one 8-bit register per word
// Notes: byte address of a register is four times its index
`ifndef GPP_MAP_SVH
`define GPP_MAP_SVH

// ==========================================
// register indices
`define GPP_IDX_LED_EN 12'hf82
`define GPP_IDX_OUT_A 12'hfd3
`define GPP_IDX_OUT_B 12'hfd7
`define GPP_IDX_OUT_C 12'hfdb
`define GPP_IDX_OUT_D 12'hfdf
// control bases, the port number fills the two low bits; then the two LED level registers
`define GPP_IDX_DIR_BASE 12'he00
`define GPP_IDX_ODR_BASE 12'he04
`define GPP_IDX_ALT_BASE 12'he08
`define GPP_IDX_PULL_BASE 12'he0c
`define GPP_IDX_SMR_BASE 12'he10
`define GPP_IDX_HDRV_BASE 12'he14
`define GPP_IDX_IN_BASE 12'he18
`define GPP_IDX_LED_LVL_LO 12'he1c
`define GPP_IDX_LED_LVL_HI 12'he1d

// ==========================================
// reset values
`define GPP_RST_BYTE 8'h00
`define GPP_RST_LED_LVL 16'h0000

// ==========================================
// implemented pins per port
`define GPP_MASK_A 8'hff
`define GPP_MASK_B_FULL 8'hff
`define GPP_MASK_B_ADC 8'h3f
`define GPP_MASK_C 8'hff
`define GPP_MASK_D 8'h01

// ==========================================
// port numbers
`define GPP_PORT_C 2
`define GPP_PORT_D 3

`endif

// ---- logic/gpp_pkg.sv ----
// Purpose: shared types of the port block
// Assumes: four ports of up to eight pins
// Notes: constants live in gpp_map.svh
package gpp_pkg;

  // ==========================================
  // per-port configuration and data
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] odr;
    logic [7:0] alt;
    logic [7:0] pull;
    logic [7:0] smr;
    logic [7:0] hdrv;
    logic [7:0] dout;
  } gpp_cfg_type;

  // ==========================================
  // pad drive: level and output enable
  typedef struct packed {
    logic [7:0] value;
    logic [7:0] enable;
  } gpp_pad_type;

  typedef enum logic {
    GPP_BUS_IDLE,
    GPP_BUS_ACK
  } gpp_bus_state_type;

endpackage : gpp_pkg

// ---- logic/gpp_sync_bank.sv ----
// Purpose: two-stage synchroniser for a bank of pin inputs
// Assumes: inputs are asynchronous to clk_sys
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module gpp_sync_bank #(
  parameter int WIDTH = 32
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // raw pin levels
  output logic [WIDTH-1:0] sync_out // synchronised levels
);

  logic [WIDTH-1:0] meta_reg;

  // ==========================================
  // two flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : gpp_sync_bank

// ---- logic/gpp_pad_drive.sv ----
// Purpose: registered pad drive of one port
// Assumes: alternate-function signals come from logic on clk_sys
// Notes: each pin is worked out on its own
`timescale 1ns/1ps
module gpp_pad_drive (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input gpp_pkg::gpp_cfg_type cfg, // port configuration and data
  input wire logic [7:0] pin_mask, // implemented pins
  input wire logic out_only, // port is output only
  input wire logic [7:0] alt_value, // alternate-function level
  input wire logic [7:0] alt_enable, // alternate-function enable
  output gpp_pkg::gpp_pad_type pad // registered pad drive
);
  import gpp_pkg::*;

  logic [7:0] value_next;
  logic [7:0] enable_next;

  // ==========================================
  // per-pin drive selection
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_pin
      wire logic use_alt = cfg.alt[b] & ~out_only;
      wire logic drive_req = out_only | (use_alt ? alt_enable[b] : cfg.dir[b]);
      wire logic level = use_alt ? alt_value[b] : cfg.dout[b];
      wire logic high_blocked = level & cfg.odr[b];
      assign value_next[b] = level & pin_mask[b];
      assign enable_next[b] = drive_req & ~high_blocked & pin_mask[b];
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pad <= '0;
    end else begin
      pad <= '{value: value_next, enable: enable_next};
    end
  end

endmodule : gpp_pad_drive

// ---- logic/gpp_port_top.sv ----
// Purpose: four-port general-purpose pin block with LED drive on the third port
// Assumes: Avalon-MM slave, word addressed, data in byte lane 0
// Notes: every output comes from a flip-flop; answer one cycle after the request
`timescale 1ns/1ps
`include "gpp_map.svh"

module gpp_port_top #(
  parameter bit ADC_PRESENT = 1'b0
) (
  input wire logic clk_sys, // system clock, 40 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [11:0] avs_address, // register index
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data, lane 0 used
  input wire logic [3:0] avs_byteenable, // byte enables
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall while high
  input wire logic [3:0][7:0] pin_in, // pad input levels
  input wire logic [3:0][7:0] alt_out, // alternate-function levels
  input wire logic [3:0][7:0] alt_oe, // alternate-function enables
  output gpp_pkg::gpp_pad_type [3:0] pad_drive, // pad level and enable
  output logic [3:0][7:0] pull_up_en, // pull-up enables
  output logic [3:0][7:0] recovery_en, // stop-mode recovery enables
  output logic [3:0][7:0] high_drive_en, // high drive current select
  output logic [7:0] led_drive_on, // third-port LED current on
  output logic [15:0] led_level // third-port LED current, 2 bits a pin
);
  import gpp_pkg::*;

  // ==========================================
  // pin masks per variant
  localparam logic [7:0] MASK_B = ADC_PRESENT ? `GPP_MASK_B_ADC : `GPP_MASK_B_FULL;
  localparam logic [3:0][7:0] PIN_MASK = {`GPP_MASK_D, `GPP_MASK_C, MASK_B, `GPP_MASK_A};
  localparam logic [3:0][11:0] OUT_IDX = {
    `GPP_IDX_OUT_D, `GPP_IDX_OUT_C, `GPP_IDX_OUT_B, `GPP_IDX_OUT_A
  };

  // ==========================================
  // bus slave state
  gpp_bus_state_type state_reg;
  gpp_bus_state_type state_next;
  logic [31:0] readdata_next;
  logic [7:0] rd_byte;
  logic waitrequest_next;

  gpp_cfg_type [3:0] cfg_reg;
  logic [7:0] led_en_reg;
  logic [15:0] led_lvl_reg;
  logic [3:0][7:0] pin_sync;

  wire logic req = avs_read | avs_write;
  wire logic commit = (state_reg == GPP_BUS_ACK) & avs_write & avs_byteenable[0];
  wire logic [7:0] wbyte = avs_writedata[7:0];
  wire logic [11:0] idx_base = {avs_address[11:2], 2'b00};
  wire logic [1:0] idx_port = avs_address[1:0];

  // ==========================================
  // address decode
  wire logic hit_dir = idx_base == `GPP_IDX_DIR_BASE;
  wire logic hit_odr = idx_base == `GPP_IDX_ODR_BASE;
  wire logic hit_alt = idx_base == `GPP_IDX_ALT_BASE;
  wire logic hit_pull = idx_base == `GPP_IDX_PULL_BASE;
  wire logic hit_smr = idx_base == `GPP_IDX_SMR_BASE;
  wire logic hit_hdrv = idx_base == `GPP_IDX_HDRV_BASE;
  wire logic hit_in = idx_base == `GPP_IDX_IN_BASE;
  wire logic hit_led_en = avs_address == `GPP_IDX_LED_EN;
  wire logic hit_lvl_lo = avs_address == `GPP_IDX_LED_LVL_LO;
  wire logic hit_lvl_hi = avs_address == `GPP_IDX_LED_LVL_HI;
  logic [3:0] hit_out;
  logic [3:0][7:0] in_view;

  // ==========================================
  // per-port registers
  genvar p;
  generate
    for (p = 0; p < 4; p++) begin : g_port
      localparam logic [1:0] PN = 2'(p);
      localparam bit OUT_ONLY = (p == `GPP_PORT_D);
      wire logic sel = idx_port == PN;
      wire logic [7:0] m = PIN_MASK[p];
      wire logic [7:0] wm = wbyte & m;
      wire logic we_dir = commit & hit_dir & sel;
      wire logic we_odr = commit & hit_odr & sel;
      wire logic we_alt = commit & hit_alt & sel;
      wire logic we_pull = commit & hit_pull & sel;
      wire logic we_smr = commit & hit_smr & sel;
      wire logic we_hdrv = commit & hit_hdrv & sel;
      wire logic we_out = commit & hit_out[p];

      assign hit_out[p] = avs_address == OUT_IDX[p];
      // output-only port reads no input
      assign in_view[p] = OUT_ONLY ? 8'h00 : (pin_sync[p] & m);

      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          cfg_reg[p] <= '0;
        end else begin
          if (we_dir) cfg_reg[p].dir <= OUT_ONLY ? m : wm;
          if (we_odr) cfg_reg[p].odr <= wm;
          if (we_alt) cfg_reg[p].alt <= OUT_ONLY ? 8'h00 : wm;
          if (we_pull) cfg_reg[p].pull <= wm;
          if (we_smr) cfg_reg[p].smr <= wm;
          if (we_hdrv) cfg_reg[p].hdrv <= wm;
          if (we_out) cfg_reg[p].dout <= wm;
        end
      end

      gpp_pad_drive u_pad (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .cfg(cfg_reg[p]),
        .pin_mask(m),
        .out_only(OUT_ONLY),
        .alt_value(alt_out[p]),
        .alt_enable(alt_oe[p]),
        .pad(pad_drive[p])
      );
    end
  endgenerate

  // ==========================================
  // input synchroniser
  gpp_sync_bank #(
    .WIDTH(32)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // ==========================================
  // LED drive registers
  wire logic we_led_en = commit & hit_led_en;
  wire logic we_lvl_lo = commit & hit_lvl_lo;
  wire logic we_lvl_hi = commit & hit_lvl_hi;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      led_en_reg <= `GPP_RST_BYTE;
      led_lvl_reg <= `GPP_RST_LED_LVL;
    end else begin
      if (we_led_en) led_en_reg <= wbyte & `GPP_MASK_C;
      if (we_lvl_lo) led_lvl_reg[7:0] <= wbyte;
      if (we_lvl_hi) led_lvl_reg[15:8] <= wbyte;
    end
  end

  // current drive only where the LED alternate function is selected
  wire logic [7:0] led_on_next = led_en_reg & cfg_reg[`GPP_PORT_C].alt;

  // ==========================================
  // read mux
  always_comb begin
    rd_byte = 8'h00;
    if (hit_dir) rd_byte = cfg_reg[idx_port].dir;
    if (hit_odr) rd_byte = cfg_reg[idx_port].odr;
    if (hit_alt) rd_byte = cfg_reg[idx_port].alt;
    if (hit_pull) rd_byte = cfg_reg[idx_port].pull;
    if (hit_smr) rd_byte = cfg_reg[idx_port].smr;
    if (hit_hdrv) rd_byte = cfg_reg[idx_port].hdrv;
    if (hit_in) rd_byte = in_view[idx_port];
    if (hit_led_en) rd_byte = led_en_reg;
    if (hit_lvl_lo) rd_byte = led_lvl_reg[7:0];
    if (hit_lvl_hi) rd_byte = led_lvl_reg[15:8];
    for (int i = 0; i < 4; i++) begin
      if (hit_out[i]) rd_byte = cfg_reg[i].dout;
    end
  end

  // ==========================================
  // bus handshake: take in idle, answer in ack
  always_comb begin
    state_next = state_reg;
    waitrequest_next = 1'b1;
    readdata_next = avs_readdata;
    unique case (state_reg)
      GPP_BUS_IDLE: begin
        if (req) begin
          state_next = GPP_BUS_ACK;
          waitrequest_next = 1'b0;
          readdata_next = {24'h000000, rd_byte};
        end
      end
      GPP_BUS_ACK: begin
        state_next = GPP_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= GPP_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      avs_waitrequest <= waitrequest_next;
      avs_readdata <= readdata_next;
    end
  end

  // ==========================================
  // registered side outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pull_up_en <= '0;
      recovery_en <= '0;
      high_drive_en <= '0;
      led_drive_on <= `GPP_RST_BYTE;
      led_level <= `GPP_RST_LED_LVL;
    end else begin
      for (int i = 0; i < 4; i++) begin
        pull_up_en[i] <= cfg_reg[i].pull;
        recovery_en[i] <= cfg_reg[i].smr;
        high_drive_en[i] <= cfg_reg[i].hdrv;
      end
      led_drive_on <= led_on_next;
      led_level <= led_lvl_reg;
    end
  end

endmodule : gpp_port_top

// ---- tb/gpp_pins_model.sv ----
// Purpose: board side of the port pins
// Assumes: weak external levels on every pin
// Notes: an undriven pin shows the external level
`timescale 1ns/1ps
module gpp_pins_model (
  input gpp_pkg::gpp_pad_type [3:0] pad, // pad drive from the block
  input wire logic [3:0][7:0] ext, // external weak levels
  output logic [3:0][7:0] pin // resolved pin levels
);
  import gpp_pkg::*;
  // ==========================================
  // wire resolution
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      pin[p] = (pad[p].value & pad[p].enable) | (ext[p] & ~pad[p].enable);
    end
  end
endmodule : gpp_pins_model

// ---- tb/gpp_port_sva.sv ----
// Purpose: port checks of the pin block
// Assumes: one clock domain
// Notes: bound to the top module
`timescale 1ns/1ps
module gpp_port_sva (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [11:0] avs_address, // register index
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte enables
  input wire logic [31:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input gpp_pkg::gpp_pad_type [3:0] pad_drive, // pad drive
  input wire logic [3:0][7:0] pull_up_en, // pull-up enables
  input wire logic [7:0] led_drive_on, // LED current on
  input wire logic [15:0] led_level // LED current level
);
  import gpp_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // assertions
  sequence wr_take(logic [11:0] a);
    avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == a;
  endsequence
  req_answer_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  rd_upper_a: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  unmapped_rd_a: assert property (
    avs_read && !avs_waitrequest && avs_address == 12'h000 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  d_input_a: assert property (
    avs_read && !avs_waitrequest && avs_address == 12'he1b |-> avs_readdata == 32'h0)
    else $error("fourth port input not zero");
  d_pins_a: assert property (
    pad_drive[3].enable[7:1] == 7'h0 && pad_drive[3].value[7:1] == 7'h0)
    else $error("fourth port extra pins driven");
  led_gate_a: assert property (
    wr_take(12'hf82) |=> ##1 (led_drive_on & ~$past(avs_writedata[7:0], 2)) == 8'h0)
    else $error("LED on not enabled");
  pull_copy_a: assert property (
    wr_take(12'he0c) |=> ##1 pull_up_en[0] == $past(avs_writedata[7:0], 2))
    else $error("pull-up copy wrong");
  led_level_a: assert property (
    wr_take(12'he1c) |=> ##1 led_level[7:0] == $past(avs_writedata[7:0], 2))
    else $error("LED level wrong");
endmodule : gpp_port_sva
bind gpp_port_top gpp_port_sva chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pad_drive(pad_drive), .pull_up_en(pull_up_en),
  .led_drive_on(led_drive_on), .led_level(led_level));

// ---- tb/tb_gpio_port_data_led_drive.sv ----
// Purpose: self-checking bench of the pin block
// Assumes: main instance without converter; a second instance has the converter
// Notes: pins resolved by the board model
`timescale 1ns/1ps
module tb_gpio_port_data_led_drive;
  import gpp_pkg::*;
  logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [3:0][7:0] pin_in, alt_out, alt_oe, ext, pull_up_en, recovery_en, high_drive_en;
  gpp_pad_type [3:0] pad_drive;
  logic [7:0] led_drive_on;
  logic [15:0] led_level;
  int err_total = 0;
  int tests_run = 0;
  gpp_port_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .alt_out(alt_out), .alt_oe(alt_oe),
    .pad_drive(pad_drive), .pull_up_en(pull_up_en), .recovery_en(recovery_en),
    .high_drive_en(high_drive_en), .led_drive_on(led_drive_on), .led_level(led_level));
  gpp_pins_model pins (.pad(pad_drive), .ext(ext), .pin(pin_in));
  // converter variant: second port bits 6 and 7 absent
  gpp_pad_type [3:0] pad_adc;
  gpp_port_top #(.ADC_PRESENT(1'b1)) dut_adc (.clk_sys(clk_sys), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(),
    .avs_waitrequest(), .pin_in(pin_in), .alt_out(alt_out), .alt_oe(alt_oe),
    .pad_drive(pad_adc), .pull_up_en(), .recovery_en(), .high_drive_en(),
    .led_drive_on(), .led_level());
  // ==========================================
  // helpers
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task bus_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_wr
  task bus_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_rd
  task settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle
  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // ==========================================
  // scenarios
  task t_regs;
    logic [11:0] a [5] = '{12'hf82, 12'hfd3, 12'hfd7, 12'hfdb, 12'hfdf};
    logic [7:0] v [5] = '{8'h5a, 8'h3c, 8'hc5, 8'h96, 8'hff};
    logic [7:0] m [5] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h01};
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      bus_rd(a[i], d);
      chk(d, 32'h0);
      bus_wr(a[i], v[i]);
    end
    for (int i = 0; i < 5; i++) begin
      bus_rd(a[i], d);
      chk(d, {24'h0, v[i] & m[i]});
    end
    bus_wr(12'h000, 8'hff);
    bus_rd(12'h000, d);
    chk(d, 32'h0);
    // lane 0 disabled: the write is answered but not stored
    @(posedge clk_sys);
    avs_byteenable <= 4'he;
    bus_wr(12'hfd3, 8'h11);
    avs_byteenable <= 4'hf;
    bus_rd(12'hfd3, d);
    chk(d, 32'h3c);
    $display("t_regs done");
  endtask : t_regs
  task t_drive;
    logic [31:0] d;
    bus_wr(12'he00, 8'hff);
    bus_wr(12'hfd3, 8'ha5);
    settle;
    chk(pad_drive[0].value, 8'ha5);
    chk(pad_drive[0].enable, 8'hff);
    bus_wr(12'he04, 8'h0f);
    settle;
    chk(pad_drive[0].enable, 8'hfa);
    repeat (4) @(posedge clk_sys);
    bus_rd(12'he18, d);
    chk(d, 32'ha4);
    bus_wr(12'he00, 8'h00);
    bus_wr(12'he0c, 8'h3c);
    bus_wr(12'he10, 8'h81);
    bus_wr(12'he14, 8'h42);
    settle;
    chk(pad_drive[0].enable, 8'h00);
    chk(pull_up_en[0], 8'h3c);
    chk(recovery_en[0], 8'h81);
    chk(high_drive_en[0], 8'h42);
    $display("t_drive done");
  endtask : t_drive
  task t_alt;
    @(posedge clk_sys);
    alt_out[2] <= 8'hff;
    alt_oe[2] <= 8'h03;
    bus_wr(12'he0a, 8'h0f);
    bus_wr(12'he02, 8'hff);
    bus_wr(12'hfdb, 8'h00);
    settle;
    chk(pad_drive[2].value, 8'h0f);
    chk(pad_drive[2].enable, 8'hf3);
    bus_wr(12'hf82, 8'hff);
    bus_wr(12'he1c, 8'he4);
    bus_wr(12'he1d, 8'h1b);
    settle;
    chk(led_drive_on, 8'h0f);
    chk(led_level[7:0], 8'he4);
    chk(led_level, 16'h1be4);
    $display("t_alt done");
  endtask : t_alt
  task t_portd;
    logic [31:0] d;
    bus_wr(12'he03, 8'h00);
    bus_rd(12'he03, d);
    chk(d, 32'h01);
    bus_rd(12'he1b, d);
    chk(d, 32'h0);
    bus_wr(12'he01, 8'hff);
    bus_wr(12'hfd7, 8'hc0);
    settle;
    chk(pad_drive[3].enable, 8'h01);
    chk(pad_drive[1].value, 8'hc0);
    chk(pad_adc[1].value, 8'h00);
    chk(pad_adc[1].enable, 8'h3f);
    $display("t_portd done");
  endtask : t_portd
  // ==========================================
  // clock, reset, sequence, watchdog
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    rst_n = 1'b0;
    {avs_read, avs_write} = 2'b00;
    avs_address = 12'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    alt_out = '0;
    alt_oe = '0;
    ext = {8'h00, 8'h00, 8'h00, 8'h04};
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_drive();
    t_alt();
    t_portd();
    end_sim();
  end
  initial begin
    #200us;
    err_total++;
    end_sim();
  end
endmodule : tb_gpio_port_data_led_drive
